// file: mwcf_edge_input_queue.sv
// Edge input queue with forward and backward flow control
`timescale 1ns/1ps
module mwcf_edge_input_queue #(
    parameter int WORD_W = 32,
    parameter int DEPTH  = 4
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    // Channel from remote switch
    input  wire logic              word_present_in_i,
    input  wire logic [WORD_W-1:0] channel_word_in_i,
    output logic                   space_freed_out_o,
    // Local switch side
    mwcf_queue_if.queue            sw
);
    localparam int PW = $clog2(DEPTH);
    logic [WORD_W-1:0] mem [DEPTH];
    logic [PW-1:0]     wr_ptr;
    logic [PW-1:0]     rd_ptr;
    logic [PW:0]       count;
    logic              deq;

    assign deq = sw.dequeue_ack && (count != '0);
    assign sw.head_word_available = (count != '0);
    assign sw.head_word_value     = mem[rd_ptr];

    // Sender guarantees room, so no full check
    always_ff @(posedge clk_i) begin
        if (word_present_in_i) begin
            mem[wr_ptr] <= channel_word_in_i;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (word_present_in_i) begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (deq) begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            count <= count + (PW+1)'(word_present_in_i) - (PW+1)'(deq);
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            space_freed_out_o <= 1'b0;
        end else begin
            space_freed_out_o <= deq;
        end
    end
endmodule : mwcf_edge_input_queue

// file: mwcf_neighbour_sink.sv
// Neighbour input queues behind the switch outputs
`timescale 1ns/1ps
module mwcf_neighbour_sink #(
    parameter int NPORT = 5,
    parameter int DEPTH = 4
) (
    input  wire logic             clk_i,
    input  wire logic             stall_i,
    input  wire logic [NPORT-1:0] word_present_i,
    output logic      [NPORT-1:0] space_freed_o,
    output logic                  overflow_o
);
    int fill [NPORT] = '{default: 0};
    initial space_freed_o = '0;
    initial overflow_o = 1'b0;
    // Drains at a random pace; a word is not readable on its arrival edge
    always @(posedge clk_i) begin
        for (int p = 0; p < NPORT; p++) begin
            logic pop;
            pop = fill[p] > 0 && !stall_i && $urandom_range(1, 0) == 1;
            fill[p] = fill[p] - int'(pop) + int'(word_present_i[p]);
            space_freed_o[p] <= pop;
            if (fill[p] > DEPTH) overflow_o <= 1'b1;
        end
    end
endmodule : mwcf_neighbour_sink

// file: mwcf_pkg.sv
// Package with shared constants and types for the mesh word crossbar switch
package mwcf_pkg;
    localparam int MWCF_WORD_W    = 32;
    localparam int MWCF_NPORT     = 5;
    localparam int MWCF_QDEPTH    = 4;
    localparam int MWCF_ROUTE_LEN = 8;
    localparam int MWCF_SEL_W     = 3;
    localparam logic [MWCF_SEL_W-1:0] MWCF_SEL_NONE = 3'h7;
    localparam logic [2:0] MWCF_CREDIT_MAX = 3'h4;
    localparam logic [2:0] MWCF_CREDIT_ONE = 3'h1;
    localparam logic [2:0] MWCF_CREDIT_ZERO = 3'h0;
    typedef enum logic [1:0] {MWCF_IDLE, MWCF_RUN} mwcf_state_t;
endpackage : mwcf_pkg

// file: mwcf_queue_if.sv
// Interface between an edge input queue and the local switch
`timescale 1ns/1ps
interface mwcf_queue_if #(parameter int WORD_W = 32);
    logic              head_word_available;
    logic [WORD_W-1:0] head_word_value;
    logic              dequeue_ack;
    modport queue  (output head_word_available, output head_word_value, input dequeue_ack);
    modport switch (input head_word_available, input head_word_value, output dequeue_ack);
endinterface : mwcf_queue_if

// file: mwcf_switch.sv
// Top of the per-tile static mesh switch: input queues, route sequencer, crossbar
`timescale 1ns/1ps
module mwcf_switch
    import mwcf_pkg::*;
#(
    parameter int WORD_W    = mwcf_pkg::MWCF_WORD_W,
    parameter int NPORT     = mwcf_pkg::MWCF_NPORT,
    parameter int QDEPTH    = mwcf_pkg::MWCF_QDEPTH,
    parameter int ROUTE_LEN = mwcf_pkg::MWCF_ROUTE_LEN
) (
    // Clock and reset
    input  wire logic                                      clk_i,
    input  wire logic                                      resetn_i,
    // Route program load (one step per write)
    input  wire logic                                      route_wr_i,
    input  wire logic [$clog2(ROUTE_LEN)-1:0]              route_addr_i,
    input  wire logic [NPORT-1:0][mwcf_pkg::MWCF_SEL_W-1:0] route_data_i,
    input  wire logic [$clog2(ROUTE_LEN)-1:0]              route_last_i,
    input  wire logic                                      run_i,
    // Incoming channels (port NPORT-1 is the local processor)
    input  wire logic [NPORT-1:0]                          word_present_in_i,
    input  wire logic [NPORT-1:0][WORD_W-1:0]              channel_word_in_i,
    output logic      [NPORT-1:0]                          space_freed_out_o,
    // Outgoing channels
    output logic      [NPORT-1:0]                          word_present_out_o,
    output logic      [NPORT-1:0][WORD_W-1:0]              channel_word_out_o,
    input  wire logic [NPORT-1:0]                          space_freed_in_i,
    // Status
    output logic                                           stalled_o,
    output logic      [$clog2(ROUTE_LEN)-1:0]              route_pc_o
);
    import mwcf_pkg::*;
    localparam int AW = $clog2(ROUTE_LEN);

    // Reset enters at once, leaves on the clock
    logic rst_meta;
    logic rst_n;
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    // Route store: per output, which input feeds it, or none
    logic [NPORT-1:0][MWCF_SEL_W-1:0] route_mem [ROUTE_LEN];
    logic [NPORT-1:0][MWCF_SEL_W-1:0] cur_route;
    logic [NPORT-1:0]                 head_avail;
    logic [NPORT-1:0][WORD_W-1:0]     head_val;
    logic [NPORT-1:0]                 deq_ack;
    logic [NPORT-1:0][2:0]            credit;
    logic [NPORT-1:0]                 src_need;
    logic [NPORT-1:0]                 dst_need;
    // Step control
    logic                             go;
    logic [NPORT-1:0]                 dst_room;
    logic                             step;
    mwcf_state_t                      state;

    function automatic logic sel_valid(input logic [MWCF_SEL_W-1:0] s);
        sel_valid = (s != MWCF_SEL_NONE) && (int'(s) < NPORT);
    endfunction : sel_valid

    // One edge input queue per incoming channel
    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            mwcf_queue_if #(.WORD_W(WORD_W)) qif ();
            mwcf_edge_input_queue #(.WORD_W(WORD_W), .DEPTH(QDEPTH)) u_q (
                .clk_i             (clk_i),
                .resetn_i          (rst_n),
                .word_present_in_i (word_present_in_i[gi]),
                .channel_word_in_i (channel_word_in_i[gi]),
                .space_freed_out_o (space_freed_out_o[gi]),
                .sw                (qif.queue)
            );
            assign head_avail[gi]       = qif.head_word_available;
            assign head_val[gi]         = qif.head_word_value;
            assign qif.dequeue_ack      = deq_ack[gi];
        end
    endgenerate

    // Route store has no reset; load it before raising run
    always_ff @(posedge clk_i) begin
        if (route_wr_i) begin
            route_mem[route_addr_i] <= route_data_i;
        end
    end

    assign cur_route = route_mem[route_pc_o];

    // Need maps for this step; stall if source empty or destination full
    always_comb begin
        src_need = '0;
        dst_need = '0;
        for (int o = 0; o < NPORT; o++) begin
            if (sel_valid(cur_route[o])) begin
                dst_need[o] = 1'b1;
                src_need[cur_route[o]] = 1'b1;
            end
        end
    end

    // Sources first: a missing head word holds the whole step
    always_comb begin
        go = (state == MWCF_RUN);
        for (int i = 0; i < NPORT; i++) begin
            if (src_need[i] && !head_avail[i]) begin
                go = 1'b0;
            end
        end
    end

    // Then destinations: a needed output without credit holds it as well
    always_comb begin
        for (int o = 0; o < NPORT; o++) begin
            dst_room[o] = (credit[o] != MWCF_CREDIT_ZERO);
        end
    end

    assign step = go && ((dst_need & ~dst_room) == '0);

    // All sources of a step dequeue together so words leave in program order;
    // a source that feeds several outputs is still dequeued once
    assign deq_ack = step ? src_need : '0;

    // Dropping run parks the sequencer at step zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            state <= MWCF_IDLE;
        end else begin
            unique case (state)
                MWCF_IDLE: begin
                    if (run_i) state <= MWCF_RUN;
                end
                MWCF_RUN: begin
                    if (!run_i) state <= MWCF_IDLE;
                end
            endcase
        end
    end

    // Wraps after the last loaded step
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            route_pc_o <= '0;
        end else if (state == MWCF_IDLE) begin
            route_pc_o <= '0;
        end else if (step) begin
            route_pc_o <= (route_pc_o == route_last_i) ? '0 : route_pc_o + 1'b1;
        end
    end

    // Reports the edge before: running but no step taken
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            stalled_o <= 1'b0;
        end else begin
            stalled_o <= (state == MWCF_RUN) && !step;
        end
    end

    // Registered outputs: one wire segment per cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            word_present_out_o <= '0;
        end else begin
            for (int o = 0; o < NPORT; o++) begin
                word_present_out_o[o] <= step && dst_need[o];
            end
        end
    end

    // Word holds between sends; only the flag marks a new one
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            channel_word_out_o <= '0;
        end else begin
            for (int o = 0; o < NPORT; o++) begin
                if (step && dst_need[o]) begin
                    channel_word_out_o[o] <= head_val[cur_route[o]];
                end
            end
        end
    end

    // Conservative credit per remote queue, starting at its depth. A freed
    // pulse returns three edges after a send at the earliest, which four
    // entries cover at one word per cycle.
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            credit <= {NPORT{MWCF_CREDIT_MAX}};
        end else begin
            for (int o = 0; o < NPORT; o++) begin
                credit[o] <= credit[o] - ((step && dst_need[o]) ? MWCF_CREDIT_ONE : MWCF_CREDIT_ZERO)
                                       + (space_freed_in_i[o] ? MWCF_CREDIT_ONE : MWCF_CREDIT_ZERO);
            end
        end
    end
endmodule : mwcf_switch

// file: mwcf_switch_props.sv
// Port checker for the mesh word switch
`timescale 1ns/1ps
module mwcf_switch_props #(
    parameter int NPORT     = 5,
    parameter int WORD_W    = 32,
    parameter int QDEPTH    = 4,
    parameter int ROUTE_LEN = 8
) (
    input wire logic                         clk_i,
    input wire logic                         resetn_i,
    input wire logic                         run_i,
    input wire logic [NPORT-1:0]             word_present_in_i,
    input wire logic [NPORT-1:0]             space_freed_out_o,
    input wire logic [NPORT-1:0]             word_present_out_o,
    input wire logic [NPORT-1:0][WORD_W-1:0] channel_word_out_o,
    input wire logic [NPORT-1:0]             space_freed_in_i,
    input wire logic                         stalled_o,
    input wire logic [$clog2(ROUTE_LEN)-1:0] route_pc_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    int owed [NPORT];
    int held [NPORT];
    // Sender view of remote fill, and local fill not yet freed
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            owed <= '{default: 0};
            held <= '{default: 0};
        end else begin
            for (int p = 0; p < NPORT; p++) begin
                owed[p] <= owed[p] + int'(word_present_out_o[p]) - int'(space_freed_in_i[p]);
                held[p] <= held[p] + int'(word_present_in_i[p]) - int'(space_freed_out_o[p]);
            end
        end
    end
    for (genvar p = 0; p < NPORT; p++) begin : g_port
        credit_keep_a: assert property (owed[p] <= QDEPTH) else $error("word sent without room");
        freed_balance_a: assert property (held[p] >= 0) else $error("space freed with no word");
    end
    step_not_stall_a: assert property (word_present_out_o != '0 |-> !stalled_o) else $error("stall flag wrong");
    stall_hold_pc_a: assert property (stalled_o |-> route_pc_o == $past(route_pc_o)) else $error("pc moved");
    pc_walk_a: assert property ($changed(route_pc_o) |-> route_pc_o == $past(route_pc_o) + 1'b1 || route_pc_o == '0)
        else $error("pc jumped");
    idle_quiet_a: assert property (!run_i |-> ##2 word_present_out_o == '0) else $error("send while stopped");
    out_hold_a: assert property (word_present_out_o == '0 |-> $stable(channel_word_out_o)) else $error("word moved");
    freed_lag_a: assert property (space_freed_out_o != '0 |-> word_present_out_o != '0)
        else $error("freed without step");
endmodule : mwcf_switch_props

// file: tb.sv
// Self-checking bench for the mesh word switch
`timescale 1ns/1ps
module tb;
    import mwcf_pkg::*;
    localparam int NP = MWCF_NPORT;
    localparam int STEPS = 24;
    logic                           clk_i = 1'b0;
    logic                           resetn_i = 1'b0;
    logic                           route_wr_i = 1'b0;
    logic [2:0]                     route_addr_i = '0;
    logic [NP-1:0][MWCF_SEL_W-1:0]  route_data_i = '0;
    logic [2:0]                     route_last_i = 3'h7;
    logic                           run_i = 1'b0;
    logic                           sink_stall = 1'b0;
    logic [NP-1:0]                  word_present_in_i = '0;
    logic [NP-1:0][MWCF_WORD_W-1:0] channel_word_in_i = '0;
    logic [NP-1:0]                  space_freed_out_o, word_present_out_o, space_freed_in_i;
    logic [NP-1:0][MWCF_WORD_W-1:0] channel_word_out_o;
    logic                           stalled_o, overflow;
    logic [2:0]                     route_pc_o;
    int                             bad_count = 0;
    int                             num_checks = 0;
    int                             credit [NP] = '{default: 4};
    logic [MWCF_WORD_W-1:0]         src_q [NP][$];
    logic [MWCF_WORD_W-1:0]         exp_q [NP][$];
    mwcf_switch u_mwcf_switch (.clk_i, .resetn_i, .route_wr_i, .route_addr_i, .route_data_i, .route_last_i,
        .run_i, .word_present_in_i, .channel_word_in_i, .space_freed_out_o, .word_present_out_o,
        .channel_word_out_o, .space_freed_in_i, .stalled_o, .route_pc_o);
    mwcf_neighbour_sink u_mwcf_neighbour_sink (.clk_i, .stall_i(sink_stall), .word_present_i(word_present_out_o),
        .space_freed_o(space_freed_in_i), .overflow_o(overflow));
    always #12.5 clk_i = ~clk_i;
    // Permuted sources, with a none code and an out-of-range code as corners
    function automatic logic [2:0] sel_of(int s, int o);
        if (s == 3 && o == 0) return MWCF_SEL_NONE;
        if (s == 5 && o == 2) return 3'h5;
        return 3'((o + s) % NP);
    endfunction : sel_of
    function automatic int exp_left();
        int n = 0;
        for (int o = 0; o < NP; o++) n += exp_q[o].size();
        return n;
    endfunction : exp_left
    task automatic chk(input logic [MWCF_WORD_W-1:0] got, input logic [MWCF_WORD_W-1:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic complete_run();
        $display("checks=%0d mismatches=%0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : complete_run
    // Upstream sender keeps its own credit; outputs scored in order
    always @(posedge clk_i) begin
        for (int i = 0; i < NP; i++) begin
            logic go;
            if (space_freed_out_o[i]) credit[i]++;
            go = run_i && src_q[i].size() > 0 && credit[i] > 0 && $urandom_range(3, 0) != 0;
            word_present_in_i[i] <= go;
            if (go) channel_word_in_i[i] <= src_q[i].pop_front();
            if (go) credit[i]--;
        end
        for (int o = 0; o < NP; o++)
            if (word_present_out_o[o]) chk(channel_word_out_o[o], exp_q[o].pop_front());
    end
    initial begin
        logic [MWCF_WORD_W-1:0] w;
        void'($urandom(23599));
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            for (int o = 0; o < NP; o++) route_data_i[o] <= sel_of(s, o);
            route_addr_i <= 3'(s);
            route_wr_i <= 1'b1;
            @(posedge clk_i);
        end
        route_wr_i <= 1'b0;
        for (int k = 0; k < STEPS; k++) begin
            for (int o = 0; o < NP; o++) begin
                if (sel_of(k % 8, o) < NP) begin
                    w = $urandom();
                    src_q[sel_of(k % 8, o)].push_back(w);
                    exp_q[o].push_back(w);
                end
            end
        end
        run_i <= 1'b1;
        repeat (40) @(posedge clk_i);
        sink_stall <= 1'b1;
        repeat (30) @(posedge clk_i);
        sink_stall <= 1'b0;
        for (int n = 0; n < 5000 && exp_left() > 0; n++) @(posedge clk_i);
        repeat (4) @(posedge clk_i);
        chk(32'(exp_left()), '0);
        chk(32'(overflow), '0);
        chk(32'(route_pc_o), '0);
        chk(32'(stalled_o), 32'h1);
        run_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(32'(stalled_o), '0);
        chk(32'(route_pc_o), '0);
        complete_run();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        complete_run();
    end
endmodule : tb
bind mwcf_switch mwcf_switch_props #(.NPORT(NPORT), .WORD_W(WORD_W), .QDEPTH(QDEPTH), .ROUTE_LEN(ROUTE_LEN))
    u_mwcf_switch_props (.clk_i, .resetn_i, .run_i, .word_present_in_i, .space_freed_out_o,
    .word_present_out_o, .channel_word_out_o, .space_freed_in_i, .stalled_o, .route_pc_o);
